//--- mbhp_cfg.svh
// Constants of the multi-bus host port
`ifndef MBHP_CFG_SVH
`define MBHP_CFG_SVH
`define MBHP_MEM_BYTES    32768
`define MBHP_MEM_AW       15
`define MBHP_REG_COUNT    16
`define MBHP_DATA_W       8
`define MBHP_HI_ADDR_W    15
`define MBHP_REG_BASE     16'h8000
`define MBHP_SYNC_W       27
`define MBHP_STROBE_CYC   8
`define MBHP_SETUP_CYC    2
`define MBHP_GAP_CYC      4
`define MBHP_CMD_SET_PTR  8'h01
`define MBHP_CMD_MEM_WR   8'h02
`define MBHP_CMD_MEM_RD   8'h03
`define MBHP_CMD_RESET    8'h00
`define MBHP_STRAP_DIRECT 1'b1
`define MBHP_DATA_IDLE    8'hFF
`endif

//--- mbhp_pkg.sv
// Types of the multi-bus host port
`default_nettype none
package mbhp_pkg;
    typedef enum logic [1:0] {
        MBHP_BUS_GENERIC = 2'h0,
        MBHP_BUS_DSTROBE = 2'h1,
        MBHP_BUS_ECLOCK  = 2'h2,
        MBHP_BUS_SPARE   = 2'h3
    } mbhp_bus_type;
    typedef enum logic [4:0] {
        MBHP_H_IDLE   = 5'h01,
        MBHP_H_SETUP  = 5'h02,
        MBHP_H_STROBE = 5'h04,
        MBHP_H_GAP    = 5'h08,
        MBHP_H_DONE   = 5'h10
    } mbhp_host_state_type;
endpackage : mbhp_pkg
`default_nettype wire

//--- mbhp_if.sv
// Pin-level link between the host processor and the display controller port
`timescale 1ns/1ps
`default_nettype none
`include "mbhp_cfg.svh"
interface mbhp_if;
    logic [14:0] addr_hi;
    logic        lowest_address_pin;
    logic        strobe_pin;
    logic        wr_pin;
    logic        cs_n;
    logic [1:0]  shift_clock_cfg_pins;
    logic [1:0]  bus_type_select_pins;
    logic        addressing_mode_pin;
    logic [7:0]  host_dout;
    logic        host_doe;
    logic [7:0]  dev_dout;
    logic        dev_doe;
    logic [7:0]  data_bus;
    // Resolved data wire; an undriven bus floats to the pull-up level
    assign data_bus = dev_doe ? dev_dout : (host_doe ? host_dout : `MBHP_DATA_IDLE);
    modport dev (
        input  addr_hi, lowest_address_pin, strobe_pin, wr_pin, cs_n,
        input  shift_clock_cfg_pins, bus_type_select_pins, addressing_mode_pin,
        input  data_bus,
        output dev_dout, dev_doe
    );
    modport host (
        output addr_hi, lowest_address_pin, strobe_pin, wr_pin, cs_n,
        output shift_clock_cfg_pins, bus_type_select_pins, addressing_mode_pin,
        output host_dout, host_doe,
        input  data_bus
    );
endinterface : mbhp_if
`default_nettype wire

//--- mbhp_host.sv
// Host processor end: turns user requests into pin cycles of the chosen bus
`timescale 1ns/1ps
`default_nettype none
`include "mbhp_cfg.svh"
module mbhp_host (
    // Clock and reset
    input  wire logic                  CLOCK,
    input  wire logic                  RESET,
    // Board straps
    input  wire mbhp_pkg::mbhp_bus_type BUS_TYPE,
    input  wire logic                  DIRECT_MODE,
    input  wire logic [1:0]            SHIFT_CFG,
    // Request
    input  wire logic                  REQ_VALID,
    input  wire logic                  REQ_WRITE,
    input  wire logic [15:0]           REQ_ADDR,
    input  wire logic [7:0]            REQ_WDATA,
    output logic                       REQ_READY,
    // Answer
    output logic                       RSP_VALID,
    output logic [7:0]                 RSP_RDATA,
    // Pins
    mbhp_if.host                       bus
);
    import mbhp_pkg::*;
    mbhp_host_state_type state_reg;
    logic [3:0]  count_reg;
    logic        write_reg;
    logic [7:0]  din_s1_reg;
    logic [7:0]  din_s2_reg;
    logic        direct_eff;
    assign direct_eff = DIRECT_MODE && (BUS_TYPE != MBHP_BUS_ECLOCK);

    always_ff @(posedge CLOCK) begin
        din_s1_reg <= bus.data_bus;
        din_s2_reg <= din_s1_reg;
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            state_reg <= MBHP_H_IDLE;
            count_reg <= 4'h0;
            write_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                MBHP_H_IDLE: begin
                    if (REQ_VALID) begin
                        write_reg <= REQ_WRITE;
                        count_reg <= 4'(`MBHP_SETUP_CYC - 1);
                        state_reg <= MBHP_H_SETUP;
                    end
                end
                MBHP_H_SETUP: begin
                    if (count_reg == 4'h0) begin
                        count_reg <= 4'(`MBHP_STROBE_CYC - 1);
                        state_reg <= MBHP_H_STROBE;
                    end else begin
                        count_reg <= count_reg - 4'h1;
                    end
                end
                MBHP_H_STROBE: begin
                    if (count_reg == 4'h0) begin
                        count_reg <= 4'(`MBHP_GAP_CYC - 1);
                        state_reg <= MBHP_H_GAP;
                    end else begin
                        count_reg <= count_reg - 4'h1;
                    end
                end
                MBHP_H_GAP: begin
                    if (count_reg == 4'h0) begin
                        state_reg <= MBHP_H_DONE;
                    end else begin
                        count_reg <= count_reg - 4'h1;
                    end
                end
                MBHP_H_DONE: begin
                    state_reg <= MBHP_H_IDLE;
                end
            endcase
        end
    end

    // Straps follow the board inputs through reset, so they are settled when it ends
    always_ff @(posedge CLOCK) begin
        bus.shift_clock_cfg_pins <= SHIFT_CFG;
        bus.bus_type_select_pins <= BUS_TYPE;
        bus.addressing_mode_pin  <= DIRECT_MODE;
    end

    // Pin drive per bus type; strobe levels flip with the protocol
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            bus.addr_hi              <= 15'h0000;
            bus.lowest_address_pin   <= 1'b0;
            bus.cs_n                 <= 1'b1;
            // Idle level of the strapped bus, so no false strobe edge follows reset
            bus.strobe_pin           <= (BUS_TYPE != MBHP_BUS_ECLOCK);
            bus.wr_pin               <= 1'b1;
            bus.host_dout            <= 8'h00;
            bus.host_doe             <= 1'b0;
        end else begin
            if (state_reg == MBHP_H_IDLE && REQ_VALID) begin
                bus.addr_hi            <= direct_eff ? REQ_ADDR[15:1] : 15'h0000;
                bus.lowest_address_pin <= REQ_ADDR[0];
                bus.host_dout          <= REQ_WDATA;
                bus.host_doe           <= REQ_WRITE;
                bus.cs_n               <= 1'b0;
                bus.wr_pin             <= (BUS_TYPE == MBHP_BUS_GENERIC) ? 1'b1 : !REQ_WRITE;
            end else if (state_reg == MBHP_H_SETUP && count_reg == 4'h0) begin
                unique case (BUS_TYPE)
                    MBHP_BUS_ECLOCK: bus.strobe_pin <= 1'b1;
                    MBHP_BUS_DSTROBE: bus.strobe_pin <= 1'b0;
                    default: begin
                        bus.strobe_pin <= write_reg;
                        bus.wr_pin     <= !write_reg;
                    end
                endcase
            end else if (state_reg == MBHP_H_STROBE && count_reg == 4'h0) begin
                bus.strobe_pin <= (BUS_TYPE != MBHP_BUS_ECLOCK);
                bus.wr_pin     <= 1'b1;
            end else if (state_reg == MBHP_H_GAP && count_reg == 4'h0) begin
                bus.cs_n     <= 1'b1;
                bus.host_doe <= 1'b0;
            end else if (state_reg == MBHP_H_IDLE) begin
                bus.strobe_pin <= (BUS_TYPE != MBHP_BUS_ECLOCK);
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            REQ_READY <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP_RDATA <= 8'h00;
        end else begin
            REQ_READY <= (state_reg == MBHP_H_IDLE) && !REQ_VALID;
            RSP_VALID <= (state_reg == MBHP_H_GAP) && (count_reg == 4'h0);
            if (state_reg == MBHP_H_STROBE && count_reg == 4'h0 && !write_reg) begin
                RSP_RDATA <= din_s2_reg;
            end
        end
    end
endmodule : mbhp_host
`default_nettype wire

//--- mbhp_device.sv
// Display controller end: host port decode, display memory and shift clock
`timescale 1ns/1ps
`default_nettype none
`include "mbhp_cfg.svh"
module mbhp_device #(
    parameter int MEM_BYTES = `MBHP_MEM_BYTES,
    parameter int REG_COUNT = `MBHP_REG_COUNT
) (
    // Clock and reset
    input  wire logic                  CLOCK,
    input  wire logic                  RESET,
    // Panel side
    output logic                       PANEL_SHIFT_CLOCK,
    // Status seen by the display engine
    output mbhp_pkg::mbhp_bus_type     BUS_TYPE,
    output logic                       DIRECT_MODE,
    output logic [7:0]                 LAST_CMD,
    output logic                       WRITE_PULSE,
    // Pins
    mbhp_if.dev                        bus
);
    import mbhp_pkg::*;

    localparam int AW = `MBHP_MEM_AW;

    // Pin synchronisers: cs, strobe, wr, lowest address, upper address, data
    logic [26:0] pin_s1_reg;
    logic [26:0] pin_s2_reg;
    logic [4:0]  strap_s1_reg;
    logic [4:0]  strap_s2_reg;

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            pin_s1_reg <= 27'h7FF_FFFF;
            pin_s2_reg <= 27'h7FF_FFFF;
        end else begin
            pin_s1_reg <= {bus.cs_n, bus.strobe_pin, bus.wr_pin, bus.lowest_address_pin,
                           bus.addr_hi, bus.data_bus};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            strap_s1_reg <= 5'h00;
            strap_s2_reg <= 5'h00;
        end else begin
            strap_s1_reg <= {bus.addressing_mode_pin, bus.bus_type_select_pins,
                             bus.shift_clock_cfg_pins};
            strap_s2_reg <= strap_s1_reg;
        end
    end

    logic        cs_n_s;
    logic        strobe_s;
    logic        wr_s;
    logic        a0_s;
    logic [14:0] addr_hi_s;
    logic [7:0]  din_s;
    assign cs_n_s    = pin_s2_reg[26];
    assign strobe_s  = pin_s2_reg[25];
    assign wr_s      = pin_s2_reg[24];
    assign a0_s      = pin_s2_reg[23];
    assign addr_hi_s = pin_s2_reg[22:8];
    assign din_s     = pin_s2_reg[7:0];

    // Straps are static; they are captured once, some cycles after reset
    logic [1:0]   shift_cfg_reg;
    mbhp_bus_type bus_type_reg;
    logic         direct_reg;
    logic [1:0]   strap_wait_reg;
    logic         strap_done_reg;

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            shift_cfg_reg  <= 2'h0;
            bus_type_reg   <= MBHP_BUS_GENERIC;
            direct_reg     <= 1'b0;
            strap_wait_reg <= 2'h0;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_wait_reg <= strap_wait_reg + 2'h1;
            if (strap_wait_reg == 2'h3) begin
                strap_done_reg <= 1'b1;
                shift_cfg_reg  <= strap_s2_reg[1:0];
                bus_type_reg   <= mbhp_bus_type'(strap_s2_reg[3:2]);
                // The enable-clocked bus has no direct mode
                direct_reg     <= (strap_s2_reg[4] == `MBHP_STRAP_DIRECT) &&
                                  (mbhp_bus_type'(strap_s2_reg[3:2]) != MBHP_BUS_ECLOCK);
            end
        end
    end

    // Whether a transfer strobe is asserted on the current bus type
    function automatic logic strobe_active(mbhp_bus_type bt, logic stb, logic wr);
        unique case (bt)
            MBHP_BUS_DSTROBE: strobe_active = !stb;
            MBHP_BUS_ECLOCK:  strobe_active = stb;
            default:          strobe_active = !stb || !wr;
        endcase
    endfunction : strobe_active

    // Whether the transfer is a read
    function automatic logic is_read(mbhp_bus_type bt, logic stb, logic wr);
        unique case (bt)
            MBHP_BUS_DSTROBE: is_read = wr;
            MBHP_BUS_ECLOCK:  is_read = wr;
            default:          is_read = !stb;
        endcase
    endfunction : is_read

    logic act_now;
    logic act_prev_reg;
    logic start;
    logic rd_now;
    assign act_now = strap_done_reg && !cs_n_s && strobe_active(bus_type_reg, strobe_s, wr_s);
    assign start   = act_now && !act_prev_reg;
    assign rd_now  = is_read(bus_type_reg, strobe_s, wr_s);

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            act_prev_reg <= 1'b0;
        end else begin
            act_prev_reg <= act_now;
        end
    end

    // Address decode
    logic [15:0] full_addr;
    logic        dir_mem;
    logic        dir_reg;
    assign full_addr = {addr_hi_s, a0_s};
    assign dir_mem   = full_addr < 16'(MEM_BYTES);
    assign dir_reg   = !dir_mem && (full_addr >= `MBHP_REG_BASE) &&
                       (full_addr < `MBHP_REG_BASE + 16'(REG_COUNT));

    // Indirect: lowest pin high is command write/data read, low is parameter or data write/command byte read back
    logic [7:0]    cmd_reg;
    logic [AW-1:0] ptr_reg;
    logic          ptr_hi_reg;
    logic [7:0]    mem [MEM_BYTES];
    logic [7:0]    regs [REG_COUNT];
    logic          mem_we;
    logic [AW-1:0] mem_idx;
    logic          reg_we;

    always_comb begin
        mem_we  = 1'b0;
        reg_we  = 1'b0;
        mem_idx = ptr_reg;
        if (direct_reg) begin
            mem_idx = full_addr[AW-1:0];
            mem_we  = start && !rd_now && dir_mem;
            reg_we  = start && !rd_now && dir_reg;
        end else begin
            // Upper address pins play no part here
            mem_we = start && !rd_now && !a0_s && (cmd_reg == `MBHP_CMD_MEM_WR);
        end
    end

    always_ff @(posedge CLOCK) begin
        if (mem_we) begin
            mem[mem_idx] <= din_s;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs[i] <= 8'h00;
            end
        end else if (reg_we) begin
            regs[full_addr[3:0]] <= din_s;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            cmd_reg    <= `MBHP_CMD_RESET;
            ptr_reg    <= '0;
            ptr_hi_reg <= 1'b0;
        end else if (start && !direct_reg) begin
            if (!rd_now && a0_s) begin
                cmd_reg    <= din_s;
                ptr_hi_reg <= 1'b0;
            end else if (!rd_now && cmd_reg == `MBHP_CMD_SET_PTR) begin
                ptr_hi_reg <= !ptr_hi_reg;
                if (ptr_hi_reg) begin
                    ptr_reg[AW-1:8] <= din_s[AW-9:0];
                end else begin
                    ptr_reg[7:0] <= din_s;
                end
            end else if ((mem_we || (rd_now && a0_s && cmd_reg == `MBHP_CMD_MEM_RD))) begin
                ptr_reg <= ptr_reg + 1'b1;
            end
        end
    end

    // Read data and output enable
    logic [7:0] rdata;
    always_comb begin
        rdata = 8'h00;
        if (direct_reg) begin
            if (dir_mem) begin
                rdata = mem[mem_idx];
            end else if (dir_reg) begin
                rdata = regs[full_addr[3:0]];
            end
        end else if (a0_s) begin
            rdata = mem[ptr_reg];
        end else begin
            rdata = cmd_reg;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            bus.dev_dout <= 8'h00;
            bus.dev_doe  <= 1'b0;
        end else begin
            if (start && rd_now) begin
                bus.dev_dout <= rdata;
            end
            bus.dev_doe <= act_now && rd_now;
        end
    end

    // Panel shift clock: divide by 2, 4, 8 or 16 as strapped
    logic [3:0] div_reg;
    logic [3:0] div_half;
    assign div_half = 4'((1 << shift_cfg_reg) - 1);

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            div_reg           <= 4'h0;
            PANEL_SHIFT_CLOCK <= 1'b0;
        end else if (strap_done_reg) begin
            if (div_reg >= div_half) begin
                div_reg           <= 4'h0;
                PANEL_SHIFT_CLOCK <= !PANEL_SHIFT_CLOCK;
            end else begin
                div_reg <= div_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            BUS_TYPE    <= MBHP_BUS_GENERIC;
            DIRECT_MODE <= 1'b0;
            LAST_CMD    <= `MBHP_CMD_RESET;
            WRITE_PULSE <= 1'b0;
        end else begin
            BUS_TYPE    <= bus_type_reg;
            DIRECT_MODE <= direct_reg;
            LAST_CMD    <= cmd_reg;
            WRITE_PULSE <= start && !rd_now;
        end
    end
endmodule : mbhp_device
`default_nettype wire

//--- mbhp_props.sv
// Checker of the pin link between the host and display controller ends
`timescale 1ns/1ps
`default_nettype none
module mbhp_props
    import mbhp_pkg::*;
(
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RESET,
    // Link pins
    input  wire logic [14:0] addr_hi,
    input  wire logic        strobe_pin,
    input  wire logic        wr_pin,
    input  wire logic        cs_n,
    input  wire logic [1:0]  shift_clock_cfg_pins,
    input  wire logic [1:0]  bus_type_select_pins,
    input  wire logic        addressing_mode_pin,
    input  wire logic        host_doe,
    input  wire logic        dev_doe
);
    import mbhp_pkg::*;
    logic       act;
    logic       act_reg;
    logic [3:0] idle_reg;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RESET);
    // Shared strobe in its active sense for the strapped bus
    assign act = (bus_type_select_pins == MBHP_BUS_ECLOCK) ? strobe_pin : !strobe_pin;
    always_ff @(posedge CLOCK) begin
        act_reg <= RESET ? 1'b0 : act;
    end
    // Cycles since the strobe went inactive, saturating
    always_ff @(posedge CLOCK) begin
        if (RESET || act)
            idle_reg <= 4'h0;
        else if (idle_reg != 4'hF)
            idle_reg <= idle_reg + 4'h1;
    end
    sequence s_read_on;
        act && !act_reg && wr_pin && !cs_n;
    endsequence
    sequence s_drive_hold;
        dev_doe [*4];
    endsequence
    a_reset_data: assert property (disable iff (1'b0) RESET |=> !dev_doe)
        else $error("data bus driven during reset");
    a_no_contention: assert property (!(dev_doe && host_doe))
        else $error("both ends drive the data bus");
    a_indirect_ground: assert property (!addressing_mode_pin && !cs_n |-> addr_hi == 15'h0000)
        else $error("upper address not grounded in indirect mode");
    a_eclock_ground: assert property (
        bus_type_select_pins == MBHP_BUS_ECLOCK && !cs_n |-> addr_hi == 15'h0000)
        else $error("upper address used on enable-clocked bus");
    a_straps_static: assert property (
        $stable({shift_clock_cfg_pins, bus_type_select_pins, addressing_mode_pin}))
        else $error("configuration straps changed");
    a_drive_in_strobe: assert property (dev_doe |-> idle_reg <= 4'h4)
        else $error("data driven outside the read strobe");
    a_read_answer: assert property (s_read_on |-> ##[1:4] s_drive_hold)
        else $error("read strobe not answered with data");
    a_write_no_drive: assert property (!wr_pin && !cs_n |-> !dev_doe)
        else $error("device drives data during a write");
    c_read: cover property (s_read_on);
endmodule : mbhp_props
`default_nettype wire

//--- multi_bus_host_port_bench.sv
// Self-checking bench of both port ends joined by the pin link
`timescale 1ns/1ps
`default_nettype none
module multi_bus_host_port_bench;
    import mbhp_pkg::*;
    logic         clock;
    logic         reset;
    mbhp_bus_type bus_type;
    logic         direct_mode;
    logic [1:0]   shift_cfg;
    logic         req_valid;
    logic         req_write;
    logic [15:0]  req_addr;
    logic [7:0]   req_wdata;
    logic         req_ready;
    logic         rsp_valid;
    logic [7:0]   rsp_rdata;
    logic         panel_clk;
    mbhp_bus_type dev_bus_type;
    logic         dev_direct;
    logic [7:0]   last_cmd;
    logic         write_pulse;
    int           n_fail;
    int           n_checks;
    int           n_wp;
    mbhp_if link ();
    mbhp_host mbhp_host_i (
        .CLOCK(clock), .RESET(reset), .BUS_TYPE(bus_type), .DIRECT_MODE(direct_mode),
        .SHIFT_CFG(shift_cfg), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
        .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .REQ_READY(req_ready),
        .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .bus(link)
    );
    mbhp_device mbhp_device_i (
        .CLOCK(clock), .RESET(reset), .PANEL_SHIFT_CLOCK(panel_clk),
        .BUS_TYPE(dev_bus_type), .DIRECT_MODE(dev_direct), .LAST_CMD(last_cmd),
        .WRITE_PULSE(write_pulse), .bus(link)
    );
    mbhp_props mbhp_props_i (
        .CLOCK(clock), .RESET(reset), .addr_hi(link.addr_hi), .strobe_pin(link.strobe_pin),
        .wr_pin(link.wr_pin), .cs_n(link.cs_n),
        .shift_clock_cfg_pins(link.shift_clock_cfg_pins),
        .bus_type_select_pins(link.bus_type_select_pins),
        .addressing_mode_pin(link.addressing_mode_pin),
        .host_doe(link.host_doe), .dev_doe(link.dev_doe)
    );
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) begin
        if (write_pulse === 1'b1)
            n_wp++;
    end
    task automatic finish_test();
        $display("Checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask : chk
    // One request on the user side, held until the answer pulse
    task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        int i;
        @(negedge clock);
        req_valid = 1'b1;
        req_write = w;
        req_addr  = a;
        req_wdata = d;
        for (i = 0; i < 40 && rsp_valid !== 1'b1; i++)
            @(negedge clock);
        if (rsp_valid !== 1'b1) begin
            $display("Error transfer expected answer seen none");
            n_fail++;
        end
        q = rsp_rdata;
        req_valid = 1'b0;
    endtask : xfer
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] q;
        xfer(1'b0, a, 8'h00, q);
        chk("read data", e, q);
    endtask : rd
    // Straps change only while reset is held
    task automatic cfg(input mbhp_bus_type bt, input logic dm, input logic [1:0] sc);
        @(negedge clock);
        reset       = 1'b1;
        bus_type    = bt;
        direct_mode = dm;
        shift_cfg   = sc;
        repeat (3) @(negedge clock);
        reset = 1'b0;
        repeat (14) @(negedge clock);
    endtask : cfg
    task automatic shift_chk(input int n);
        int   c;
        logic p;
        p = panel_clk;
        for (c = 0; c < 40 && panel_clk === p; c++)
            @(negedge clock);
        p = panel_clk;
        c = 0;
        while (c < 40 && panel_clk === p) begin
            @(negedge clock);
            c++;
        end
        chk("shift half period", 8'(1 << n), 8'(c));
    endtask : shift_chk
    task automatic dir_test();
        wr(16'h0000, 8'h5A);
        wr(16'h0001, 8'hA5);
        wr(16'h7FFF, 8'h3C);
        rd(16'h0000, 8'h5A);
        rd(16'h0001, 8'hA5);
        rd(16'h7FFF, 8'h3C);
        wr(16'h8003, 8'hC3);
        rd(16'h8003, 8'hC3);
        wr(16'h9000, 8'h77);
        rd(16'h9000, 8'h00);
    endtask : dir_test
    task automatic ind_test(input logic [7:0] lo, input logic [7:0] d0);
        n_wp = 0;
        wr(16'hFF01, 8'h01);
        wr(16'hFE00, lo);
        wr(16'h0000, 8'h00);
        wr(16'h0001, 8'h02);
        wr(16'h0000, d0);
        wr(16'h0000, ~d0);
        wr(16'h0001, 8'h01);
        wr(16'h0000, lo);
        wr(16'h0000, 8'h00);
        wr(16'h0001, 8'h03);
        rd(16'h0001, d0);
        rd(16'h0001, ~d0);
        rd(16'h0000, 8'h03);
        chk("command byte", 8'h03, last_cmd);
        chk("write pulses", 8'd10, 8'(n_wp));
    endtask : ind_test
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        $display("Error watchdog expected end seen timeout");
        finish_test();
    end
    initial begin
        reset = 1'b1;
        bus_type = MBHP_BUS_GENERIC;
        direct_mode = 1'b1;
        shift_cfg = 2'h0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 16'h0000;
        req_wdata = 8'h00;
        n_fail = 0;
        n_checks = 0;
        n_wp = 0;
        repeat (2) @(negedge clock);
        cfg(MBHP_BUS_GENERIC, 1'b1, 2'h0);
        chk("bus type", 8'h00, {6'h00, dev_bus_type});
        chk("direct mode", 8'h01, {7'h00, dev_direct});
        chk("host ready", 8'h01, {7'h00, req_ready});
        shift_chk(0);
        dir_test();
        $display("Test 1 done");
        cfg(MBHP_BUS_DSTROBE, 1'b1, 2'h3);
        chk("bus type", 8'h01, {6'h00, dev_bus_type});
        shift_chk(3);
        dir_test();
        $display("Test 2 done");
        cfg(MBHP_BUS_ECLOCK, 1'b1, 2'h2);
        chk("bus type", 8'h02, {6'h00, dev_bus_type});
        chk("direct mode", 8'h00, {7'h00, dev_direct});
        shift_chk(2);
        ind_test(8'h10, 8'h96);
        $display("Test 3 done");
        cfg(MBHP_BUS_GENERIC, 1'b0, 2'h1);
        chk("direct mode", 8'h00, {7'h00, dev_direct});
        shift_chk(1);
        ind_test(8'h20, 8'h69);
        $display("Test 4 done");
        finish_test();
    end
endmodule : multi_bus_host_port_bench
`default_nettype wire
